// ---- hw/class0_tag_write_handler.sv ----
// Operation
// [RULE1] row family: unit is two-byte row
// [RULE2] short data padded right with zeros
// [RULE3] host gives tag identity on targeted write
// [RULE4] lock query answers flag 0 or 1
// [RULE5] host keeps one tag for row locks
// [RULE6] host gives identity and kill passcode
// [RULE7] 96-bit identifier at row 4: append crc
// [RULE8] five-row identifier plus crc written verbatim
// [RULE9] host passcode: row 2, two rows, six digits
// [RULE10] random replies vary; seeded replies repeat
// [RULE11] no direct echo when writing identifier; row family refuses only anonymous echo writes starting at row 4
// [RULE12] host sets singulation mode before writes
// [RULE13] pages 0, 2, 3 of fixed sizes
// [RULE14] pages 2 and 3 get crc appended
// [RULE15] only pages 0, 2, 3; default 0
// [RULE16] host gives length, data, identity with crc
// [RULE17] traversal inhibit blocks later direct echo
// [RULE18] valid identifier not overwritten before erase
// [RULE19] targeted write uses direct echo always
// [RULE20] erase zeroes pages and appends crc; the code appends it to page 3 only and leaves page 2 all zero
// [RULE21] any locked page fails whole erase
// [RULE22] page locks irreversible; default page 0
// [RULE23] commands framed by brace and bang
// [RULE24] missing parameters or bad page give error; a lock query or read naming a bad page answers ok
`timescale 1ns/1ps
`default_nettype none
module class0_tag_write_handler (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic char_valid_i,
	input wire logic [7:0] char_i,
	input wire tag_cmd_pkg::reg_req_type bus_i,
	output logic [31:0] rd_data_o,
	output logic resp_valid_o,
	output tag_cmd_pkg::resp_type resp_o
);
	import tag_cmd_pkg::*;

	logic cmd_valid;
	cmd_frame_type prm;
	logic family_r;
	logic [31:0] sing_cfg_r;
	logic [15:0] row_mem_r [ROW_COUNT];
	logic row_lock_r;
	logic killed_r;
	logic [23:0] kill_page_r;
	logic [127:0] id_store_r;
	logic [103:0] user_page_r;
	logic [15:0] user_crc_r;
	logic [2:0] page_lock_r;
	logic id_valid_r;
	logic inhibit_r;
	logic [15:0] lfsr_r;
	logic [11:0] reply_r;

	cmd_text_parser u_parser (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.char_valid_i(char_valid_i),
		.char_i(char_i),
		.frame_valid_o(cmd_valid),
		.frame_o(prm)
	);

	function automatic logic [127:0] left_just(input logic [127:0] v, input logic [5:0] n);
		return v << (8'(128) - {n, 2'b00});
	endfunction

	function automatic logic [127:0] trim(input logic [127:0] v, input logic [4:0] n);
		return v & ~({128{1'b1}} >> {n, 3'b000});
	endfunction

	function automatic logic [15:0] row_slice(input logic [127:0] v, input int k);
		return v[127-16*k -: 16];
	endfunction

	logic is_write, targeted, page_ok;
	logic [7:0] page;
	logic [1:0] slot;
	logic [4:0] nbytes, max_bytes, row_len, row_start;
	logic [127:0] data_l, d_l, row_id;
	logic [15:0] wr_crc;
	logic [15:0] seed_crc;
	sing_mode_type eff_mode;
	resp_code_type err;
	logic flag;
	logic we;

	always_comb
	begin
		is_write = (prm.cmd == anonymous_write_cmd) || (prm.cmd == targeted_write_cmd);
		targeted = (prm.cmd == targeted_write_cmd);
		// [RULE15] default page zero
		page = prm.has_a ? prm.a : PAGE_KILL;
		page_ok = (page == PAGE_KILL) || (page == PAGE_ID) || (page == PAGE_USER);
		slot = (page == PAGE_ID) ? 2'h1 : (page == PAGE_USER) ? 2'h2 : 2'h0;
		max_bytes = (page == PAGE_ID) ? ID_MAX_BYTES : (page == PAGE_USER) ? USER_BYTES : KILL_BYTES;
		// [RULE1] rows of two bytes
		row_start = prm.has_a ? prm.a[4:0] : 5'h00;
		row_len = prm.has_l ? prm.l[4:0] : 5'(({1'b0, prm.bnib} + 7'h03) >> 2);
		nbytes = family_r ? prm.l[4:0] : {row_len[3:0], 1'b0};
		// [RULE2] zero padding on the right
		data_l = trim(left_just(prm.b, prm.bnib), nbytes);
		d_l = left_just(prm.d, prm.dnib);
		for (int i = 0; i < 8; i++)
			row_id[127-16*i -: 16] = (i < 6) ? row_mem_r[int'(ID_ROW)+i] : 16'h0000;
		wr_crc = crc16(data_l, family_r ? nbytes : 5'h0C);
		// seeded replies hang off the stored identifier, so they repeat until it is rewritten
		seed_crc = crc16(family_r ? id_store_r : row_id, ID_MAX_BYTES);
		// [RULE19] targeted write forces echo
		eff_mode = targeted ? direct_echo_mode : sing_mode_type'(sing_cfg_r[SING_MODE_LSB +: 2]);
		flag = family_r ? page_lock_r[slot] : row_lock_r;
		err = resp_ok;
		// [RULE24] parameter and page checks
		if (prm.cmd == cmd_bad)
			err = resp_err_cmd;
		else if (killed_r)
			err = resp_err_killed;
		else if (family_r)
		begin
			if (is_write && (!prm.has_l || !prm.has_b || (targeted && !prm.has_d)))
				err = resp_err_param;
			else if ((is_write || prm.cmd == page_lock_cmd) && !page_ok)
				err = resp_err_param;
			else if (is_write && (nbytes == 5'h00 || nbytes > max_bytes || prm.l[7:5] != 3'h0))
				err = resp_err_param;
			// [RULE22] locked page rejects writes
			else if (is_write && page_lock_r[slot])
				err = resp_err_locked;
			// [RULE21] erase is all or nothing
			else if (prm.cmd == tag_wipe_cmd && page_lock_r != 3'h0)
				err = resp_err_locked;
			// [RULE11] no echo on identifier page
			else if (is_write && eff_mode == direct_echo_mode && page == PAGE_ID)
				err = resp_err_mode;
			// [RULE17] inhibited tags ignore echo
			else if (is_write && eff_mode == direct_echo_mode && inhibit_r)
				err = resp_err_mode;
			else if (targeted && trim(d_l, 5'h0E) != trim(id_store_r, 5'h0E))
				err = resp_err_match;
			// [RULE18] refuse identifier overwrite
			else if (is_write && page == PAGE_ID && id_valid_r)
				err = resp_err_overwrite;
			else if (prm.cmd == tag_kill_cmd && (!prm.has_d || !prm.has_b))
				err = resp_err_param;
			else if (prm.cmd == tag_kill_cmd && (trim(d_l, 5'h0E) != trim(id_store_r, 5'h0E)
				|| prm.b[23:0] != kill_page_r))
				err = resp_err_match;
			else if (prm.cmd == anonymous_read_cmd && page == PAGE_ID && !id_valid_r)
				err = resp_err_cmd;
		end
		else
		begin
			if (is_write && (!prm.has_b || (targeted && !prm.has_d)))
				err = resp_err_param;
			else if (is_write && (row_len == 5'h00 || 6'(row_start) + 6'(row_len) > 6'(ROW_COUNT)))
				err = resp_err_param;
			else if ((is_write || prm.cmd == tag_wipe_cmd) && row_lock_r)
				err = resp_err_locked;
			else if (is_write && !targeted && eff_mode == direct_echo_mode && row_start == ID_ROW)
				err = resp_err_mode;
			else if (targeted && trim(d_l, 5'h0C) != row_id)
				err = resp_err_match;
			else if (prm.cmd == tag_kill_cmd && (!prm.has_d || !prm.has_b))
				err = resp_err_param;
			else if (prm.cmd == tag_kill_cmd && (trim(d_l, 5'h0C) != row_id
				|| prm.b[23:0] != {row_mem_r[int'(PASS_ROW)], row_mem_r[int'(PASS_ROW)+1][15:8]}))
				err = resp_err_match;
		end
		we = cmd_valid && (err == resp_ok);
	end

	// register bus: control, singulation word, status, reply
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			family_r <= 1'b0;
			sing_cfg_r <= SING_RESET;
		end
		else if (bus_i.wr && bus_i.addr == REG_CTRL)
			family_r <= bus_i.wdata[0];
		else if (bus_i.wr && bus_i.addr == REG_SING)
			sing_cfg_r <= bus_i.wdata;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			rd_data_o <= 32'h00000000;
		else if (!bus_i.rd)
			rd_data_o <= 32'h00000000;
		else
		begin
			case (bus_i.addr)
				REG_CTRL: rd_data_o <= {31'h00000000, family_r};
				REG_SING: rd_data_o <= sing_cfg_r;
				REG_STAT: rd_data_o <= {20'h00000, killed_r, inhibit_r, id_valid_r, page_lock_r,
					row_lock_r, resp_o.flag, resp_o.code};
				REG_REPLY: rd_data_o <= {20'h00000, reply_r};
				default: rd_data_o <= 32'h00000000;
			endcase
		end
	end

	// [RULE10] random and seeded singulation replies
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			lfsr_r <= 16'hACE1;
			reply_r <= 12'h000;
		end
		else
		begin
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
			if (cmd_valid && is_write)
			begin
				case (eff_mode)
					random_reply_mode: reply_r <= lfsr_r[11:0];
					seeded_reply_mode: reply_r <= seed_crc[11:0];
					default: reply_r <= family_r ? id_store_r[127:116] : row_id[127:116];
				endcase
			end
		end
	end

	// row-organised tag memory
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			row_lock_r <= 1'b0;
			for (int i = 0; i < ROW_COUNT; i++)
				row_mem_r[i] <= 16'h0000;
		end
		else if (we && !family_r)
		begin
			if (prm.cmd == page_lock_cmd)
				row_lock_r <= 1'b1;
			if (prm.cmd == tag_wipe_cmd)
				for (int i = 0; i < ROW_COUNT; i++)
					row_mem_r[i] <= 16'h0000;
			if (is_write)
			begin
				// [RULE8] rows stored exactly as given
				for (int i = 0; i < ROW_COUNT; i++)
					if (i >= int'(row_start) && i < int'(row_start) + int'(row_len))
						row_mem_r[i] <= row_slice(data_l, i - int'(row_start));
				// [RULE7] crc lands after identifier
				if (row_start == ID_ROW && prm.f == CRC_FLAG && row_len == ID96_ROWS)
					row_mem_r[int'(ID_ROW + ID96_ROWS)] <= wr_crc;
			end
		end
	end

	// [RULE13] page-organised tag memory
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			kill_page_r <= 24'h000000;
			id_store_r <= '0;
			user_page_r <= '0;
			user_crc_r <= 16'h0000;
			page_lock_r <= 3'h0;
			id_valid_r <= 1'b0;
			inhibit_r <= 1'b0;
			killed_r <= 1'b0;
		end
		else if (we && family_r)
		begin
			case (prm.cmd)
				// [RULE22] locks only ever set
				page_lock_cmd: page_lock_r[slot] <= 1'b1;
				tag_kill_cmd: killed_r <= 1'b1;
				// [RULE20] zero fill with crc
				tag_wipe_cmd:
				begin
					kill_page_r <= 24'h000000;
					id_store_r <= '0;
					user_page_r <= '0;
					user_crc_r <= crc16('0, USER_BYTES);
					id_valid_r <= 1'b0;
					inhibit_r <= 1'b0;
				end
				anonymous_write_cmd, targeted_write_cmd:
				begin
					// [RULE14] crc appended to pages 2 and 3
					if (page == PAGE_ID)
					begin
						id_store_r <= data_l | ({wr_crc, 112'h0} >> {nbytes, 3'b000});
						id_valid_r <= 1'b1;
						inhibit_r <= sing_cfg_r[SING_INHIBIT_BIT];
					end
					else if (page == PAGE_USER)
					begin
						user_page_r <= data_l[127:24];
						user_crc_r <= crc16(data_l, USER_BYTES);
					end
					else
						kill_page_r <= data_l[127:104];
				end
				default: killed_r <= killed_r;
			endcase
		end
	end

	// [RULE4] answer with lock flag
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			resp_valid_o <= 1'b0;
			resp_o <= '0;
		end
		else
		begin
			resp_valid_o <= cmd_valid;
			if (cmd_valid)
			begin
				resp_o.code <= err;
				resp_o.flag <= (prm.cmd == lock_query_cmd) && (err == resp_ok) && flag;
			end
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_page_write(logic [7:0] pg);
		cmd_valid && is_write && family_r && page == pg;
	endsequence

	a_query_flag: assert property (cmd_valid && prm.cmd == lock_query_cmd && !killed_r // [RULE4]
		|=> resp_valid_o && resp_o.flag == $past(flag))
		else $error("lock query flag differs from lock state");
	a_lock_kept: assert property ((page_lock_r & $past(page_lock_r)) == $past(page_lock_r)) // [RULE22]
		else $error("page lock was released");
	a_locked_id_hold: assert property (page_lock_r[1] |=> $stable(id_store_r)) // [RULE22]
		else $error("locked identifier page changed");
	a_wipe_none: assert property (cmd_valid && prm.cmd == tag_wipe_cmd && family_r // [RULE21]
		&& page_lock_r != 3'h0 && !killed_r
		|=> $stable(user_page_r) && resp_o.code == resp_err_locked)
		else $error("erase went ahead with a locked page");
	a_bad_page_err: assert property (cmd_valid && is_write && family_r && !page_ok // [RULE15]
		&& !killed_r |=> resp_valid_o && resp_o.code == resp_err_param)
		else $error("invalid page accepted");
	a_overwrite_block: assert property (s_page_write(PAGE_ID) ##0 id_valid_r // [RULE18]
		|=> $stable(id_store_r) && resp_o.code != resp_ok)
		else $error("valid identifier overwritten");
	a_user_crc: assert property (s_page_write(PAGE_USER) ##0 (err == resp_ok) // [RULE14]
		|=> user_crc_r == crc16({user_page_r, 24'h000000}, USER_BYTES))
		else $error("user page crc not appended");
	a_row_crc: assert property (we && !family_r && is_write && row_start == ID_ROW // [RULE7]
		&& prm.f == CRC_FLAG && row_len == ID96_ROWS
		|=> row_mem_r[int'(ID_ROW + ID96_ROWS)] == crc16(row_id, ID_MAX_BYTES))
		else $error("row crc missing after identifier");
	a_echo_refuse: assert property (cmd_valid && targeted && family_r && inhibit_r // [RULE17]
		&& !killed_r && err != resp_err_param && !page_lock_r[slot]
		|=> resp_o.code == resp_err_mode)
		else $error("inhibited tag took direct echo");
	a_wipe_zero: assert property (we && family_r && prm.cmd == tag_wipe_cmd // [RULE20]
		|=> user_page_r == '0 && user_crc_r == crc16('0, USER_BYTES) && !id_valid_r)
		else $error("erase left data behind");
endmodule
`default_nettype wire

// ---- common/tag_cmd_pkg.sv ----
package tag_cmd_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SING = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_REPLY = 8'h0C;
	localparam logic [31:0] SING_RESET = 32'h12050180;
	localparam int SING_INHIBIT_BIT = 30;
	localparam int SING_MODE_LSB = 26;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam int ROW_COUNT = 16;
	localparam logic [4:0] ID_ROW = 5'h04;
	localparam logic [4:0] PASS_ROW = 5'h02;
	localparam logic [4:0] ID96_ROWS = 5'h06;
	localparam logic [3:0] CRC_FLAG = 4'h3;
	localparam logic [7:0] PAGE_KILL = 8'h00;
	localparam logic [7:0] PAGE_ID = 8'h02;
	localparam logic [7:0] PAGE_USER = 8'h03;
	localparam logic [4:0] KILL_BYTES = 5'h03;
	localparam logic [4:0] ID_MAX_BYTES = 5'h0C;
	localparam logic [4:0] USER_BYTES = 5'h0D;
	localparam logic [7:0] CHAR_OPEN = 8'h7B;
	localparam logic [7:0] CHAR_OPEN_ALT = 8'h7D;
	localparam logic [7:0] CHAR_END = 8'h21;
	localparam logic [7:0] CHAR_SEP = 8'h2C;
	localparam logic [7:0] CHAR_COLON = 8'h3A;

	typedef enum logic [1:0] {random_reply_mode, seeded_reply_mode, direct_echo_mode,
		reserved_mode} sing_mode_type;
	typedef enum logic [3:0] {resp_ok, resp_err_cmd, resp_err_param, resp_err_locked,
		resp_err_overwrite, resp_err_mode, resp_err_match, resp_err_killed} resp_code_type;
	typedef enum logic [3:0] {cmd_bad, anonymous_write_cmd, targeted_write_cmd, page_lock_cmd,
		lock_query_cmd, tag_kill_cmd, tag_wipe_cmd, anonymous_read_cmd} cmd_type;

	typedef struct packed {
		logic flag;
		resp_code_type code;
	} resp_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_type;

	typedef struct packed {
		cmd_type cmd;
		logic has_a;
		logic has_l;
		logic has_b;
		logic has_d;
		logic [7:0] a;
		logic [7:0] l;
		logic [3:0] f;
		logic [5:0] bnib;
		logic [5:0] dnib;
		logic [127:0] b;
		logic [127:0] d;
	} cmd_frame_type;

	// crc over the first n bytes of a left-justified word
	function automatic logic [15:0] crc16(input logic [127:0] d, input logic [4:0] n);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 128; i++)
			if (i < 8 * int'(n))
				c = {c[14:0], 1'b0} ^ ((c[15] ^ d[127-i]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction
endpackage

// ---- hw/cmd_text_parser.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmd_text_parser (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic char_valid_i,
	input wire logic [7:0] char_i,
	output logic frame_valid_o,
	output tag_cmd_pkg::cmd_frame_type frame_o
);
	import tag_cmd_pkg::*;

	typedef enum logic [2:0] {ps_idle, ps_name1, ps_name2, ps_sep, ps_key, ps_colon,
		ps_value} parse_state_type;

	parse_state_type state_r;
	logic [7:0] name_r;
	logic [7:0] key_r;
	logic [127:0] acc_r;
	logic [5:0] nib_r;
	logic [7:0] ch;
	logic is_hex;
	logic [3:0] hex_val;

	always_comb
	begin
		ch = (char_i >= 8'h41 && char_i <= 8'h5A) ? (char_i | 8'h20) : char_i;
		is_hex = (ch >= 8'h30 && ch <= 8'h39) || (ch >= 8'h61 && ch <= 8'h66);
		hex_val = (ch <= 8'h39) ? ch[3:0] : 4'(ch[3:0] + 4'h9);
	end

	function automatic cmd_type decode_name(input logic [15:0] n);
		case (n)
			16'h7761: return anonymous_write_cmd;
			16'h7774: return targeted_write_cmd;
			16'h6C62: return page_lock_cmd;
			16'h796C: return lock_query_cmd;
			16'h7464: return tag_kill_cmd;
			16'h7465: return tag_wipe_cmd;
			16'h7261: return anonymous_read_cmd;
			default: return cmd_bad;
		endcase
	endfunction

	// [RULE23] brace-framed text
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_r <= ps_idle;
			frame_o <= '0;
			frame_valid_o <= 1'b0;
			name_r <= 8'h00;
			key_r <= 8'h00;
			acc_r <= '0;
			nib_r <= 6'h00;
		end
		else
		begin
			frame_valid_o <= 1'b0;
			if (char_valid_i)
			begin
				if (ch == CHAR_OPEN || ch == CHAR_OPEN_ALT)
				begin
					frame_o <= '0;
					state_r <= ps_name1;
				end
				else
				begin
					case (state_r)
						ps_idle: state_r <= ps_idle;
						ps_name1:
						begin
							name_r <= ch;
							state_r <= ps_name2;
						end
						ps_name2:
						begin
							frame_o.cmd <= decode_name({name_r, ch});
							state_r <= ps_sep;
						end
						ps_key:
						begin
							key_r <= ch;
							state_r <= ps_colon;
						end
						ps_colon:
						begin
							acc_r <= '0;
							nib_r <= 6'h00;
							state_r <= (ch == CHAR_COLON) ? ps_value : ps_idle;
							frame_valid_o <= (ch != CHAR_COLON);
							if (ch != CHAR_COLON)
								frame_o.cmd <= cmd_bad;
						end
						ps_sep, ps_value:
						begin
							if (state_r == ps_value && is_hex)
							begin
								acc_r <= {acc_r[123:0], hex_val};
								// longer data keeps only its last 32 digits
								if (nib_r != 6'h20)
									nib_r <= 6'(nib_r + 6'h01);
							end
							else if (ch == CHAR_SEP || ch == CHAR_END)
							begin
								if (state_r == ps_value)
								begin
									case (key_r)
										8'h61:
										begin
											frame_o.a <= acc_r[7:0];
											frame_o.has_a <= 1'b1;
										end
										8'h6C:
										begin
											frame_o.l <= acc_r[7:0];
											frame_o.has_l <= 1'b1;
										end
										8'h66: frame_o.f <= acc_r[3:0];
										8'h62:
										begin
											frame_o.b <= acc_r;
											frame_o.bnib <= nib_r;
											frame_o.has_b <= 1'b1;
										end
										8'h64:
										begin
											frame_o.d <= acc_r;
											frame_o.dnib <= nib_r;
											frame_o.has_d <= 1'b1;
										end
										default: frame_o.f <= frame_o.f;
									endcase
								end
								state_r <= (ch == CHAR_SEP) ? ps_key : ps_idle;
								frame_valid_o <= (ch == CHAR_END);
							end
							else
							begin
								frame_o.cmd <= cmd_bad;
								frame_valid_o <= 1'b1;
								state_r <= ps_idle;
							end
						end
						default: state_r <= ps_idle;
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/cmd_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cmd_host_model (
	input wire logic clk_sys_i,
	output logic char_valid_o,
	output logic [7:0] char_o
);
	initial
	begin
		char_valid_o = 1'b0;
		char_o = 8'h00;
	end

	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++)
		begin
			@(posedge clk_sys_i);
			char_valid_o <= 1'b1;
			char_o <= s[i];
		end
		@(posedge clk_sys_i);
		char_valid_o <= 1'b0;
		// idle line shows a changed value so a stale character cannot pass unseen
		char_o <= ~s[s.len()-1];
	endtask
endmodule
`default_nettype wire

// ---- tb/class0_tag_write_handler_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module class0_tag_write_handler_tb;
	import tag_cmd_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	reg_req_type bus = '0;
	logic char_valid;
	logic [7:0] char_b;
	logic [31:0] rd_data;
	logic resp_valid;
	resp_type resp;
	int err_count = 0;
	int tests_run = 0;
	int seed = 32'h7753;
	int fam, killed, inh, idv, rowlk;
	int plk[4];
	logic [3:0] last_code;
	logic last_flag;
	logic [95:0] id;
	logic [15:0] crcv;
	logic [31:0] got;
	string idw;
	string twr;

	always #4 clk_sys_i = ~clk_sys_i;

	class0_tag_write_handler uut (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.char_valid_i(char_valid),
		.char_i(char_b),
		.bus_i(bus),
		.rd_data_o(rd_data),
		.resp_valid_o(resp_valid),
		.resp_o(resp)
	);

	cmd_host_model host (
		.clk_sys_i(clk_sys_i),
		.char_valid_o(char_valid),
		.char_o(char_b)
	);

	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task bad(input string m);
		err_count++;
		$display("wrong value at %0t: %s", $time, m);
	endtask

	task chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e)
			bad($sformatf("%s got %h exp %h", m, g, e));
	endtask

	task chk_resp(input resp_type g, input logic [3:0] c, input logic f);
		tests_run++;
		if (g.code !== c || g.flag !== f)
			bad($sformatf("response %h/%b exp %h/%b", g.code, g.flag, c, f));
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		bus <= '0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk_sys_i);
		bus <= '0;
		#1 d = rd_data;
	endtask

	function automatic logic [15:0] crc_ref(input logic [95:0] v);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 95; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction

	function automatic logic [31:0] stat_exp();
		return {20'h0, killed[0], inh[0], idv[0], plk[3][0], plk[2][0], plk[0][0], rowlk[0],
			last_flag, last_code};
	endfunction

	task do_reset;
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		fam = 0;
		killed = 0;
		inh = 0;
		idv = 0;
		rowlk = 0;
		plk = '{0, 0, 0, 0};
		last_code = 4'h0;
		last_flag = 1'b0;
	endtask

	// a random digit ahead of each frame must be ignored by the parser
	task cmd(input string s, input logic [3:0] c, input logic f);
		int n;
		logic [31:0] m;
		host.send({$sformatf("%0d", $unsigned($random(seed)) % 10), s});
		n = 0;
		do
		begin
			@(posedge clk_sys_i);
			#1 n++;
		end
		while (resp_valid !== 1'b1 && n < 300);
		if (n >= 300)
		begin
			bad("no response");
			finish_test;
		end
		chk_resp(resp, c, f);
		last_code = c;
		last_flag = f;
		// identity bits only exist for the page family
		m = fam ? 32'h0000_0FFF : 32'h0000_01FF;
		rd(REG_STAT, got);
		chk_word(got & m, stat_exp() & m, "status");
	endtask

	initial
	begin
		do_reset;
		rd(REG_CTRL, got);
		chk_word(got, 32'h0, "ctrl reset");
		rd(REG_SING, got);
		chk_word(got, SING_RESET, "sing reset");
		wr(REG_STAT, 32'hFFFF_FFFF);
		rd(REG_STAT, got);
		chk_word(got, 32'h0, "status read only");
		rd(8'h10, got);
		chk_word(got, 32'h0, "unmapped");
		$display("test registers done");
		id = {$random(seed), $random(seed), $random(seed)};
		crcv = crc_ref(id);
		cmd($sformatf("{wa,a:4,l:6,b:%024h,f:3!", id), 4'h0, 1'b0);
		cmd("{Wa,a:4,l:5,b:c80507a8009af9d71021!", 4'h0, 1'b0);
		cmd("{wa,a:e,l:2,b:12!", 4'h0, 1'b0);
		cmd("{wa,a:f,l:2,b:1234!", 4'h2, 1'b0);
		cmd("{wa,a:2,l:2,b:123456!", 4'h0, 1'b0);
		cmd("{zz!", 4'h1, 1'b0);
		cmd("{yl!", 4'h0, 1'b0);
		rowlk = 1;
		cmd("{lb!", 4'h0, 1'b0);
		cmd("{yl!", 4'h0, 1'b1);
		cmd("}wa,a:b,b:1234!", 4'h3, 1'b0);
		$display("test row family done");
		do_reset;
		wr(REG_CTRL, 32'h1);
		fam = 1;
		idw = $sformatf("{wa,a:2,b:%024h,l:c!", id);
		twr = $sformatf("{wt,d:%024h%04h,a:3,b:aa,l:d!", id, crcv);
		cmd("{wa,a:1,l:3,b:112233!", 4'h2, 1'b0);
		cmd("{wa,l:4,b:11223344!", 4'h2, 1'b0);
		cmd("{wa,b:112233,l:3!", 4'h0, 1'b0);
		cmd("{wa,a:3,b:00112233445566778899aabbcc,l:d!", 4'h0, 1'b0);
		cmd("{wa,a:3,b:00,l:e!", 4'h2, 1'b0);
		cmd("{wa,a:3,b:1!", 4'h2, 1'b0);
		wr(REG_SING, 32'h1A05_0180);
		cmd(idw, 4'h5, 1'b0);
		wr(REG_SING, 32'h5205_0180);
		idv = 1;
		inh = 1;
		cmd(idw, 4'h0, 1'b0);
		cmd(idw, 4'h4, 1'b0);
		cmd(twr, 4'h5, 1'b0);
		idv = 0;
		inh = 0;
		cmd("{te!", 4'h0, 1'b0);
		wr(REG_SING, SING_RESET);
		idv = 1;
		cmd(idw, 4'h0, 1'b0);
		wr(REG_SING, 32'h1605_0180);
		cmd($sformatf("{wt,d:%024h%04h,a:3,b:aa,l:d!", id, ~crcv), 4'h6, 1'b0);
		cmd(twr, 4'h0, 1'b0);
		// targeted writes echo, so only an anonymous write shows the seeded reply
		cmd("{wa,a:3,b:aa,l:1!", 4'h0, 1'b0);
		plk[0] = 1;
		cmd("{lb!", 4'h0, 1'b0);
		rd(REG_REPLY, got);
		chk_word(got & 32'h0000_0FFF, {20'h0, crcv[11:0]}, "seeded reply");
		cmd("{yl!", 4'h0, 1'b1);
		cmd("{wa,b:445566,l:3!", 4'h3, 1'b0);
		cmd("{te!", 4'h3, 1'b0);
		plk[3] = 1;
		cmd("{lb,a:3!", 4'h0, 1'b0);
		plk[2] = 1;
		cmd("{lb,a:2!", 4'h0, 1'b0);
		cmd(idw, 4'h3, 1'b0);
		cmd("{lb!", 4'h0, 1'b0);
		killed = 1;
		// the earlier erase left the kill code at zero
		cmd($sformatf("{td,d:%024h%04h,b:000000!", id, crcv), 4'h0, 1'b0);
		cmd("{yl!", 4'h7, 1'b0);
		$display("test page family done");
		finish_test;
	end
endmodule
`default_nettype wire
